/* core/nipc_ctrl.sv */
// Purpose: software priority registers, cpu level bits and external irq groups
// Assumes: cpu core issues one-cycle instruction and entry strobes
// Notes: vector 0 is the emergency stop; vectors 1..13 are maskable
`timescale 1ns/100ps
module nipc_ctrl #(
  parameter int NUM_VEC_P = nipc_pkg::NUM_VEC,
  parameter int NUM_GRP_P = nipc_pkg::NUM_GRP
) (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic [nipc_pkg::ADDR_W-1:0] addr_in,
  input wire logic [nipc_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [nipc_pkg::DATA_W-1:0] rdata_out,
  input wire logic [NUM_VEC_P-1:0] irq_req_in,
  input wire logic [NUM_VEC_P-1:0] irq_en_in,
  input wire logic [NUM_GRP_P*nipc_pkg::GRP_PINS-1:0] ext_pin_in,
  input wire logic [NUM_GRP_P*nipc_pkg::GRP_PINS-1:0] ext_pin_irq_cfg_in,
  input wire nipc_pkg::nipc_op_type cpu_op_in,
  input wire logic [1:0] popcc_level_in,
  input wire logic nonmask_entry_in,
  input wire logic irq_ack_in,
  output logic irq_take_out,
  output logic [3:0] irq_vec_out,
  output logic [1:0] cur_level_out,
  output logic level_masked_out,
  output logic [NUM_GRP_P-1:0] ext_pend_out
);
  import nipc_pkg::*;

  localparam int NPIN = NUM_GRP_P * GRP_PINS;

  logic [DATA_W-1:0] prio_r [4];
  logic [DATA_W-1:0] sense_r;
  logic [1:0] polar_r;
  logic [1:0] level_r;
  logic [1:0] level_nxt;
  logic masked_r;
  logic [1:0] svc_prio_r;
  logic in_isr_r;
  logic [NPIN-1:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_q_r;
  logic [NUM_GRP_P-1:0] ext_pend_r;
  logic irq_take_r;
  logic [3:0] irq_vec_r;
  logic [3:0] take_vec_r;
  logic [DATA_W-1:0] rdata_r;

  // rank of a level code: higher number is more urgent
  function automatic logic [1:0] lvl_rank(input logic [1:0] code);
    case (code)
      LVL0: lvl_rank = 2'h0;
      LVL1: lvl_rank = 2'h1;
      LVL2: lvl_rank = 2'h2;
      default: lvl_rank = 2'h3;
    endcase
  endfunction : lvl_rank

  function automatic logic [1:0] vec_prio(input int v);
    vec_prio = prio_r[v/4][(v%4)*2 +: 2];
  endfunction : vec_prio

  // per field merge, level 0 code rejected
  function automatic logic [7:0] prio_merge(input logic [7:0] old, input logic [7:0] wr);
    logic [7:0] res;
    res = old;
    for (int f = 0; f < 4; f++) begin
      if (wr[f*2 +: 2] != LVL0) begin
        res[f*2 +: 2] = wr[f*2 +: 2];
      end
    end
    prio_merge = res;
  endfunction : prio_merge

  wire sense_wr = wr_in && (addr_in == OFF_SENSE);
  wire polar_wr = wr_in && (addr_in == OFF_POLAR);
  wire cfg_change = (sense_wr && (wdata_in != sense_r)) ||
                    (polar_wr && (wdata_in[1:0] != polar_r));

  // priority registers
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < 4; i++) prio_r[i] <= PRIO_RESET;
    end else if (wr_in && addr_in <= OFF_PRIO3) begin
      prio_r[addr_in[1:0]] <= prio_merge(prio_r[addr_in[1:0]], wdata_in);
    end
  end

  // sensitivity and polarity; software keeps level 3 while writing
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sense_r <= SENSE_RESET;
      polar_r <= POLAR_RESET;
    end else begin
      if (sense_wr) sense_r <= wdata_in;
      if (polar_wr) polar_r <= wdata_in[1:0];
    end
  end

  // pin synchroniser, third stage confirms second
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pin_s1_r <= '1;
      pin_s2_r <= '1;
      pin_s3_r <= '1;
      pin_q_r <= '1;
    end else begin
      pin_s1_r <= ext_pin_in;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      for (int p = 0; p < NPIN; p++) begin
        if (pin_s2_r[p] == pin_s3_r[p]) pin_q_r[p] <= pin_s3_r[p];
      end
    end
  end

  // per group event detection
  logic [NUM_GRP_P-1:0] grp_evt;
  logic [NUM_GRP_P-1:0] grp_low;
  always_comb begin
    for (int g = 0; g < NUM_GRP_P; g++) begin
      logic rise, fall, lvl, inv;
      logic [1:0] s;
      rise = 1'b0;
      fall = 1'b0;
      lvl = 1'b0;
      grp_low[g] = 1'b0;
      s = sense_r[g*2 +: 2];
      // polarity invert exists only on groups 0 and 2
      inv = (g == 0) ? polar_r[0] : (g == 2) ? polar_r[1] : 1'b0;
      for (int k = 0; k < GRP_PINS; k++) begin
        int p;
        p = g * GRP_PINS + k;
        if (ext_pin_irq_cfg_in[p]) begin
          rise |= pin_q_r[p] && !pin_s3_r[p] ? 1'b0 : (!pin_q_r[p] && pin_s2_r[p] && pin_s3_r[p]);
          fall |= pin_q_r[p] && !pin_s2_r[p] && !pin_s3_r[p];
          lvl |= inv ? pin_q_r[p] : !pin_q_r[p];
          grp_low[g] |= !pin_q_r[p];
        end
      end
      if (inv) begin
        logic t;
        t = rise;
        rise = fall;
        fall = t;
      end
      case (s)
        SENS_FALL_LOW: grp_evt[g] = fall || lvl;
        SENS_RISE: grp_evt[g] = rise;
        SENS_FALL: grp_evt[g] = fall;
        default: grp_evt[g] = rise || fall;
      endcase
    end
  end

  // external pending latches; event wins over entry clear
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ext_pend_r <= '0;
    end else begin
      for (int g = 0; g < NUM_GRP_P; g++) begin
        if (grp_evt[g]) begin
          ext_pend_r[g] <= 1'b1;
        end else if (cfg_change) begin
          ext_pend_r[g] <= 1'b0;
        end else if (irq_ack_in && irq_vec_r == 4'(NUM_VEC_P - 1 - g)) begin
          ext_pend_r[g] <= 1'b0;
        end
      end
    end
  end

  // arbitration: highest index with priority above current level wins, unless the serviced vector re-enters above its service priority
  logic [NUM_VEC_P-1:0] req_all;
  logic take_c;
  logic [3:0] take_v;
  always_comb begin
    take_c = 1'b0;
    take_v = '0;
    for (int v = 0; v < NUM_VEC_P; v++) begin
      req_all[v] = irq_req_in[v];
      // top vectors are the external groups, masked by a held-low pin
      if (v >= NUM_VEC_P - NUM_GRP_P) begin
        req_all[v] = ext_pend_r[NUM_VEC_P - 1 - v] && !grp_low[NUM_VEC_P - 1 - v];
      end
    end
    for (int v = 1; v < NUM_VEC_P; v++) begin
      if (req_all[v] && irq_en_in[v] && lvl_rank(vec_prio(v)) > lvl_rank(level_r)) begin
        take_c = 1'b1;
        take_v = 4'(v);
      end
    end
    // re-entry of the serviced vector after a raised priority
    if (in_isr_r && req_all[take_vec_r] && irq_en_in[take_vec_r] &&
        lvl_rank(vec_prio(int'(take_vec_r))) > lvl_rank(svc_prio_r)) begin
      take_c = 1'b1;
      take_v = take_vec_r;
    end
  end

  // next level: entry events override the level instructions
  always_comb begin
    level_nxt = level_r;
    if (nonmask_entry_in) begin
      level_nxt = LVL3;
    end else if (irq_ack_in) begin
      level_nxt = vec_prio(int'(irq_vec_r));
    end else begin
      case (cpu_op_in)
        NIPC_OP_ENABLE: level_nxt = LVL0;
        NIPC_OP_DISABLE: level_nxt = LVL3;
        NIPC_OP_HALT: level_nxt = LVL0;
        NIPC_OP_WAIT: level_nxt = LVL0;
        NIPC_OP_POPCC: level_nxt = popcc_level_in;
        NIPC_OP_RETURN: level_nxt = popcc_level_in;
        default: level_nxt = level_r;
      endcase
    end
  end

  // current level bits; masked flag kept in its own flop so the output is registered
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      level_r <= LVL3;
      masked_r <= 1'b1;
    end else begin
      level_r <= level_nxt;
      masked_r <= (level_nxt == LVL3);
    end
  end

  // service bookkeeping for re-entry
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      svc_prio_r <= LVL3;
      in_isr_r <= 1'b0;
      take_vec_r <= '0;
    end else if (nonmask_entry_in) begin
      in_isr_r <= in_isr_r;
    end else if (irq_ack_in) begin
      svc_prio_r <= vec_prio(int'(irq_vec_r));
      take_vec_r <= irq_vec_r;
      in_isr_r <= 1'b1;
    end else if (cpu_op_in == NIPC_OP_RETURN) begin
      in_isr_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_take_r <= 1'b0;
      irq_vec_r <= '0;
    end else begin
      irq_take_r <= take_c && !irq_ack_in;
      if (take_c) irq_vec_r <= take_v;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_r <= '0;
    end else if (rd_in) begin
      if (addr_in <= OFF_PRIO3) begin
        rdata_r <= prio_r[addr_in[1:0]];
      end else if (addr_in == OFF_SENSE) begin
        rdata_r <= sense_r;
      end else if (addr_in == OFF_POLAR) begin
        rdata_r <= {6'h00, polar_r};
      end else if (addr_in == OFF_LEVEL) begin
        rdata_r <= {5'h00, in_isr_r, level_r};
      end else begin
        rdata_r <= {{(DATA_W-NUM_GRP_P){1'b0}}, ext_pend_r};
      end
    end
  end

  assign rdata_out = rdata_r;
  assign irq_take_out = irq_take_r;
  assign irq_vec_out = irq_vec_r;
  assign cur_level_out = level_r;
  assign level_masked_out = masked_r;
  assign ext_pend_out = ext_pend_r;
endmodule : nipc_ctrl

/* common/nipc_pkg.sv */
// Purpose: constants and types for the nested interrupt priority controller
// Assumes: 8-bit register port, 2-bit level codes shared with the cpu level bits
// Notes: offsets of the register port are local choices
package nipc_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int NUM_VEC = 14;
  localparam int NUM_GRP = 4;
  localparam int GRP_PINS = 2;
  // register offsets
  localparam logic [2:0] OFF_PRIO0 = 3'h0;
  localparam logic [2:0] OFF_PRIO1 = 3'h1;
  localparam logic [2:0] OFF_PRIO2 = 3'h2;
  localparam logic [2:0] OFF_PRIO3 = 3'h3;
  localparam logic [2:0] OFF_SENSE = 3'h4;
  localparam logic [2:0] OFF_POLAR = 3'h5;
  localparam logic [2:0] OFF_LEVEL = 3'h6;
  localparam logic [2:0] OFF_PEND = 3'h7;
  // level codes
  localparam logic [1:0] LVL0 = 2'h2;
  localparam logic [1:0] LVL1 = 2'h1;
  localparam logic [1:0] LVL2 = 2'h0;
  localparam logic [1:0] LVL3 = 2'h3;
  // group sensitivity codes
  localparam logic [1:0] SENS_FALL_LOW = 2'h0;
  localparam logic [1:0] SENS_RISE = 2'h1;
  localparam logic [1:0] SENS_FALL = 2'h2;
  localparam logic [1:0] SENS_BOTH = 2'h3;
  localparam logic [7:0] PRIO_RESET = 8'hFF;
  localparam logic [7:0] SENSE_RESET = 8'h00;
  localparam logic [1:0] POLAR_RESET = 2'h0;
  localparam int MOTOR_EMERGENCY_STOP_VEC = 0;
  // cpu level instructions
  typedef enum logic [2:0] {
    NIPC_OP_NONE, NIPC_OP_ENABLE, NIPC_OP_DISABLE, NIPC_OP_HALT,
    NIPC_OP_WAIT, NIPC_OP_POPCC, NIPC_OP_RETURN
  } nipc_op_type;
endpackage : nipc_pkg

/* test/nipc_cpu_model.sv */
// Purpose: cpu core stand-in that enters each serviceable request
// Assumes: take is a registered level from the controller
// Notes: one entry pulse per take; a gap cycle avoids double entry
`timescale 1ns/100ps
module nipc_cpu_model (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic take_in,
  output logic ack_out
);
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) ack_out <= 1'b0;
    else ack_out <= take_in && !ack_out;
  end
endmodule : nipc_cpu_model

/* test/nipc_ctrl_properties.sv */
// Purpose: port assertions for the priority controller
// Assumes: one clock domain, async active-low reset
// Notes: a shadow of the sensitivity register spots value changes
`timescale 1ns/100ps
module nipc_ctrl_properties #(
  parameter int NUM_GRP_P = 4
) (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic [nipc_pkg::ADDR_W-1:0] addr_in,
  input wire logic [nipc_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire nipc_pkg::nipc_op_type cpu_op_in,
  input wire logic [1:0] popcc_level_in,
  input wire logic nonmask_entry_in,
  input wire logic irq_ack_in,
  input wire logic irq_take_out,
  input wire logic [3:0] irq_vec_out,
  input wire logic [1:0] cur_level_out,
  input wire logic level_masked_out,
  input wire logic [NUM_GRP_P-1:0] ext_pend_out
);
  import nipc_pkg::*;
  logic [7:0] sense_sh_r;
  logic op_quiet;
  // entry events override instructions, so level checks skip those cycles
  assign op_quiet = !nonmask_entry_in && !irq_ack_in;
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) sense_sh_r <= SENSE_RESET;
    else if (wr_in && addr_in == OFF_SENSE) sense_sh_r <= wdata_in;
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  property p_en; cpu_op_in == NIPC_OP_ENABLE && op_quiet |=> cur_level_out == LVL0; endproperty
  a_en: assert property (p_en) else $error("enable gave wrong level");
  property p_dis; cpu_op_in == NIPC_OP_DISABLE && op_quiet |=> cur_level_out == LVL3; endproperty
  a_dis: assert property (p_dis) else $error("disable gave wrong level");
  property p_halt;
    cpu_op_in inside {NIPC_OP_HALT, NIPC_OP_WAIT} && op_quiet |=> cur_level_out == LVL0;
  endproperty
  a_halt: assert property (p_halt) else $error("halt or wait gave wrong level");
  property p_pop;
    cpu_op_in inside {NIPC_OP_POPCC, NIPC_OP_RETURN} && op_quiet
      |=> cur_level_out == $past(popcc_level_in);
  endproperty
  a_pop: assert property (p_pop) else $error("popped level not loaded");
  property p_nm; nonmask_entry_in |=> cur_level_out == LVL3; endproperty
  a_nm: assert property (p_nm) else $error("nonmaskable entry left level open");
  property p_mask; level_masked_out == (cur_level_out == LVL3); endproperty
  a_mask: assert property (p_mask) else $error("masked flag disagrees with level");
  property p_block; $past(cur_level_out) == LVL3 && cur_level_out == LVL3 |-> !irq_take_out;
  endproperty
  a_block: assert property (p_block) else $error("request taken at level 3");
  property p_sense;
    wr_in && addr_in == OFF_SENSE && wdata_in != sense_sh_r |=> ext_pend_out == '0;
  endproperty
  a_sense: assert property (p_sense) else $error("pending kept after sense change");
  c_ack: cover property (irq_ack_in && irq_vec_out != 4'h0);
  c_pend: cover property (ext_pend_out != '0);
  c_pop: cover property (cpu_op_in == NIPC_OP_POPCC);
endmodule : nipc_ctrl_properties

bind nipc_ctrl nipc_ctrl_properties #(.NUM_GRP_P(NUM_GRP_P)) i_nipc_ctrl_properties (
  .ref_clk_in, .rstn_in, .addr_in, .wdata_in, .wr_in, .cpu_op_in, .popcc_level_in,
  .nonmask_entry_in, .irq_ack_in, .irq_take_out, .irq_vec_out, .cur_level_out,
  .level_masked_out, .ext_pend_out
);

/* test/nipc_ctrl_tb_top.sv */
// Purpose: self-checking bench for the priority controller
// Assumes: cpu model enters each serviceable request
// Notes: level 3 is set before any sensitivity write
`timescale 1ns/100ps
module nipc_ctrl_tb_top;
  import nipc_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [2:0] addr_in = 3'h0;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [13:0] irq_req_in = 14'h0000;
  logic [13:0] irq_en_in = 14'h0000;
  logic [7:0] ext_pin_in = 8'hFF;
  logic [7:0] ext_pin_irq_cfg_in = 8'h01;
  nipc_op_type cpu_op_in = NIPC_OP_NONE;
  logic [1:0] popcc_level_in = 2'h0;
  logic nonmask_entry_in = 1'b0;
  logic irq_ack_in, irq_take_out, level_masked_out;
  logic [7:0] rdata_out;
  logic [3:0] irq_vec_out, ext_pend_out;
  logic [1:0] cur_level_out;
  int mismatches = 0;
  int comparisons = 0;
  always #4 ref_clk_in = ~ref_clk_in;
  nipc_ctrl i_nipc_ctrl (.ref_clk_in, .rstn_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .rdata_out, .irq_req_in, .irq_en_in, .ext_pin_in, .ext_pin_irq_cfg_in, .cpu_op_in,
    .popcc_level_in, .nonmask_entry_in, .irq_ack_in, .irq_take_out, .irq_vec_out,
    .cur_level_out, .level_masked_out, .ext_pend_out);
  nipc_cpu_model i_nipc_cpu_model (.ref_clk_in, .rstn_in, .take_in(irq_take_out),
    .ack_out(irq_ack_in));
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    #1 chk(rdata_out, exp);
  endtask : rd
  task automatic op(input nipc_op_type o, input logic [1:0] lv, input logic [1:0] exp);
    @(posedge ref_clk_in);
    cpu_op_in <= o;
    popcc_level_in <= lv;
    @(posedge ref_clk_in);
    cpu_op_in <= NIPC_OP_NONE;
    #1 chk({5'h00, level_masked_out, cur_level_out}, {5'h00, exp == LVL3, exp});
  endtask : op
  // bounded wait on take (pend=0) or group 0 pending (pend=1)
  task automatic wait_hi(input logic pend);
    for (int i = 0; i < 20 && (pend ? ext_pend_out[0] : irq_take_out) !== 1'b1; i++) begin
      @(posedge ref_clk_in);
      #1;
    end
    chk({7'h00, pend ? ext_pend_out[0] : irq_take_out}, 8'h01);
    if (mismatches != 0) give_verdict();
  endtask : wait_hi
  initial begin
    repeat (20) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    for (int r = 0; r < 4; r++) rd(r[2:0], PRIO_RESET);
    rd(OFF_SENSE, SENSE_RESET);
    wr(OFF_PRIO0, 8'hCF);
    wr(OFF_PRIO0, 8'h64);
    rd(OFF_PRIO0, 8'h44);
    wr(OFF_PRIO0, 8'hAA);
    rd(OFF_PRIO0, 8'h44);
    wr(OFF_PRIO2, 8'h1D);
    rd(OFF_PRIO2, 8'h1D);
    wr(OFF_PRIO1, 8'hF5);
    rd(OFF_PRIO1, 8'hF5);
    $display("test registers done");
    op(NIPC_OP_ENABLE, 2'h0, LVL0);
    op(NIPC_OP_DISABLE, 2'h0, LVL3);
    op(NIPC_OP_HALT, 2'h0, LVL0);
    op(NIPC_OP_POPCC, LVL1, LVL1);
    op(NIPC_OP_WAIT, 2'h0, LVL0);
    op(NIPC_OP_RETURN, LVL2, LVL2);
    op(NIPC_OP_ENABLE, 2'h0, LVL0);
    $display("test instructions done");
    irq_en_in <= 14'h0030;
    irq_req_in <= 14'h0020;
    wait_hi(1'b0);
    chk({4'h0, irq_vec_out}, 8'h05);
    repeat (3) @(posedge ref_clk_in);
    irq_req_in <= 14'h0010;
    #1 chk({6'h00, cur_level_out}, {6'h00, LVL1});
    repeat (8) @(posedge ref_clk_in);
    #1 chk({7'h00, irq_take_out}, 8'h00);
    @(posedge ref_clk_in);
    irq_req_in <= 14'h0000;
    nonmask_entry_in <= 1'b1;
    @(posedge ref_clk_in);
    nonmask_entry_in <= 1'b0;
    #1 chk({6'h00, cur_level_out}, {6'h00, LVL3});
    $display("test nesting done");
    wr(OFF_SENSE, {6'h00, SENS_FALL});
    rd(OFF_SENSE, 8'h02);
    @(posedge ref_clk_in);
    ext_pin_in <= 8'hFE;
    wait_hi(1'b1);
    irq_en_in <= 14'h2000;
    op(NIPC_OP_ENABLE, 2'h0, LVL0);
    repeat (2) @(posedge ref_clk_in);
    #1 chk({7'h00, irq_take_out}, 8'h00);
    op(NIPC_OP_DISABLE, 2'h0, LVL3);
    wr(OFF_SENSE, {6'h00, SENS_BOTH});
    #1 chk({4'h0, ext_pend_out}, 8'h00);
    $display("test external done");
    give_verdict();
  end
endmodule : nipc_ctrl_tb_top
